//--- design/modem_ctl_pkg.sv
package modem_ctl_pkg;
   localparam int CTL_W = 8;
   localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
   localparam int BIT_CLK_SEL = 7;
   localparam int BIT_THR_EN = 6;
   localparam int BIT_XON_ANY = 5;
   localparam int BIT_LOOP = 4;
   localparam int BIT_IRQ_EN = 3;
   localparam int BIT_FIFO_RDY = 2;
   localparam int BIT_RTS = 1;
   localparam int BIT_DTR = 0;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam logic [1:0] PRESCALE_RESET = 2'h0;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic LINE_IDLE = 1'h1;
   localparam logic PIN_N_IDLE = 1'h1;
   localparam logic [3:0] STATUS_RESET = 4'h0;
endpackage

//--- design/baud_prescaler.sv
`timescale 1ns/1ns
module baud_prescaler
   import modem_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic div4,
   output logic tick
);
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic tick_next;

   always_comb begin
      cnt_next = cnt_reg + 2'h1;
      tick_next = !div4 || (cnt_reg == PRESCALE_LAST);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= PRESCALE_RESET;
         tick <= FLAG_RESET;
      end else begin
         cnt_reg <= cnt_next;
         tick <= tick_next;
      end
   end
endmodule // baud_prescaler

//--- design/uart_modem_control_reg.sv
`timescale 1ns/1ns
// Function
// - bit 7 picks baud clock: input clock undivided, or divided by four
// - bit 6 set opens access to threshold and trigger-level registers
// - bit 5 enables resume on any received character
// - bits 7..5 writable only while enhanced-feature write enable is set
// - bit 4 loops serial transmit output back into receive input
// - in loop-back, bits 3,2,1,0 feed status bits 7,6,4,5
// - bit 3 clear: interrupt outputs floated, general-purpose output high
// - bit 3 set: interrupt outputs driven, general-purpose output low
// - bit 2 enables the combined FIFO-ready status register
// - without auto flow control, RTS output is low exactly when bit 1 set
// - with auto RTS enabled, flow-control logic decides RTS level
// - DTR output is low exactly when bit 0 set
// - outside loop-back, status bits are complements of modem inputs
module uart_modem_control_reg
   import modem_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic enhanced_write_en,
   input wire logic auto_rts_en,
   input wire logic auto_rts_level_n,
   input wire logic tx_serial,
   input wire logic rx_pin,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   input wire logic irq_a_in,
   input wire logic irq_b_in,
   output logic [7:0] modem_control,
   output logic baud_tick,
   output logic thresholds_access_en,
   output logic xon_any_en,
   output logic loopback_en,
   output logic fifo_ready_en,
   output logic rx_serial,
   output logic tx_pin,
   output logic [3:0] modem_line_status,
   output logic channel_a_irq_out,
   output logic channel_a_irq_oe,
   output logic channel_b_irq_out,
   output logic channel_b_irq_oe,
   output logic general_purpose_output,
   output logic rts_n,
   output logic dtr_n
);
   logic [CTL_W-1:0] ctl_reg;
   logic [CTL_W-1:0] ctl_next;
   logic [CTL_W-1:0] readback_next;
   logic thr_access_next;
   logic xon_any_next;
   logic loop_next;
   logic fifo_rdy_next;
   logic rx_next;
   logic tx_next;
   logic [3:0] status_next;
   logic irq_a_next;
   logic irq_a_oe_next;
   logic irq_b_next;
   logic irq_b_oe_next;
   logic gpo_next;
   logic rts_next;
   logic dtr_next;

   // active-low pin level for an active-high control bit
   function automatic logic pin_n(input logic active);
      return !active;
   endfunction

   // loop-back image of the low control bits, in status order 7,6,5,4
   function automatic logic [3:0] loop_image(input logic [CTL_W-1:0] ctl);
      return {ctl[BIT_IRQ_EN], ctl[BIT_FIFO_RDY], ctl[BIT_DTR], ctl[BIT_RTS]};
   endfunction

   // active-high status image of the four active-low modem inputs
   function automatic logic [3:0] line_image(input logic cd, input logic ri, input logic dsr,
         input logic cts);
      return {pin_n(cd), pin_n(ri), pin_n(dsr), pin_n(cts)};
   endfunction

   // upper bits are guarded by the enhanced write enable; a refused write gives
   // no indication, so software must read back to see what stuck
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_en) begin
         ctl_next[BIT_LOOP:BIT_DTR] = wr_data[BIT_LOOP:BIT_DTR];
         if (enhanced_write_en) begin
            ctl_next[BIT_CLK_SEL:BIT_XON_ANY] = wr_data[BIT_CLK_SEL:BIT_XON_ANY];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_reg <= MODEM_CONTROL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // prescaler follows the live register, so a change applies next cycle
   // the counter free-runs, so the first divided tick lands within four cycles
   baud_prescaler u_prescaler (
      .clk(clk),
      .rst(rst),
      .div4(ctl_reg[BIT_CLK_SEL]),
      .tick(baud_tick)
   );

   // read-back copy and decoded enables; every output lags the register by one cycle
   always_comb begin
      readback_next = ctl_reg;
      thr_access_next = ctl_reg[BIT_THR_EN];
      xon_any_next = ctl_reg[BIT_XON_ANY];
      loop_next = ctl_reg[BIT_LOOP];
      fifo_rdy_next = ctl_reg[BIT_FIFO_RDY];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         modem_control <= MODEM_CONTROL_RESET;
         thresholds_access_en <= FLAG_RESET;
         xon_any_en <= FLAG_RESET;
         loopback_en <= FLAG_RESET;
         fifo_ready_en <= FLAG_RESET;
      end else begin
         modem_control <= readback_next;
         thresholds_access_en <= thr_access_next;
         xon_any_en <= xon_any_next;
         loopback_en <= loop_next;
         fifo_ready_en <= fifo_rdy_next;
      end
   end

   // serial routing: the pin idles high while looped so the far end sees no traffic
   always_comb begin
      if (ctl_reg[BIT_LOOP]) begin
         rx_next = tx_serial;
         tx_next = LINE_IDLE;
      end else begin
         rx_next = rx_pin;
         tx_next = tx_serial;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_serial <= LINE_IDLE;
         tx_pin <= LINE_IDLE;
      end else begin
         rx_serial <= rx_next;
         tx_pin <= tx_next;
      end
   end

   // line status: the real modem inputs are ignored while looped back
   always_comb begin
      if (ctl_reg[BIT_LOOP]) begin
         status_next = loop_image(ctl_reg);
      end else begin
         status_next = line_image(cd_n, ri_n, dsr_n, cts_n);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         modem_line_status <= STATUS_RESET;
      end else begin
         modem_line_status <= status_next;
      end
   end

   // interrupt gating: request levels pass straight through, bit 3 only gates the enables
   always_comb begin
      irq_a_next = irq_a_in;
      irq_a_oe_next = ctl_reg[BIT_IRQ_EN];
      irq_b_next = irq_b_in;
      irq_b_oe_next = ctl_reg[BIT_IRQ_EN];
      gpo_next = pin_n(ctl_reg[BIT_IRQ_EN]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         channel_a_irq_out <= FLAG_RESET;
         channel_a_irq_oe <= FLAG_RESET;
         channel_b_irq_out <= FLAG_RESET;
         channel_b_irq_oe <= FLAG_RESET;
         general_purpose_output <= PIN_N_IDLE;
      end else begin
         channel_a_irq_out <= irq_a_next;
         channel_a_irq_oe <= irq_a_oe_next;
         channel_b_irq_out <= irq_b_next;
         channel_b_irq_oe <= irq_b_oe_next;
         general_purpose_output <= gpo_next;
      end
   end

   // modem outputs: auto flow control owns RTS while enabled and bit 1 is ignored
   // both pins reset to the inactive high level so the modem sees no request
   always_comb begin
      if (auto_rts_en) begin
         rts_next = auto_rts_level_n;
      end else begin
         rts_next = pin_n(ctl_reg[BIT_RTS]);
      end
      dtr_next = pin_n(ctl_reg[BIT_DTR]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rts_n <= PIN_N_IDLE;
         dtr_n <= PIN_N_IDLE;
      end else begin
         rts_n <= rts_next;
         dtr_n <= dtr_next;
      end
   end
endmodule // uart_modem_control_reg

//--- testbench/modem_peer.sv
`timescale 1ns/1ns
module modem_peer(
   input wire logic [3:0] peer_set,
   input wire logic tx_pin,
   output logic [3:0] lines_n,
   output logic rx_pin
);
   assign lines_n = ~peer_set;
   // null-modem echo, so a stuck transmit pin shows up on receive
   assign rx_pin = tx_pin;
endmodule // modem_peer

//--- testbench/ctl_monitor.sv
`timescale 1ns/1ns
module ctl_monitor(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic enhanced_write_en,
   input wire logic auto_rts_en,
   input wire logic auto_rts_level_n,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   input wire logic loopback_en,
   input wire logic general_purpose_output,
   input wire logic channel_a_irq_oe,
   input wire logic channel_b_irq_oe,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] modem_control,
   input wire logic [3:0] modem_line_status
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_hi_write: assert property (wr_en && enhanced_write_en |->
      ##2 modem_control[7:5] == $past(wr_data[7:5], 2)) else $error("hi lost");
   a_hi_keep: assert property (wr_en && !enhanced_write_en ##1 !wr_en |=>
      $stable(modem_control[7:5])) else $error("hi changed");
   a_dtr_level: assert property (dtr_n == !modem_control[0]) else $error("dtr");
   a_irq_gate: assert property (general_purpose_output != modem_control[3] &&
      channel_a_irq_oe == modem_control[3] && channel_b_irq_oe == modem_control[3])
      else $error("irq");
   a_rts_manual: assert property (!$past(auto_rts_en) |->
      rts_n == !modem_control[1]) else $error("rts");
   a_rts_auto: assert property (!$past(rst) && $past(auto_rts_en) |->
      rts_n == $past(auto_rts_level_n)) else $error("auto rts");
   a_loop_status: assert property (loopback_en |-> modem_line_status ==
      {modem_control[3:2], modem_control[0], modem_control[1]}) else $error("loop");
   a_status_norm: assert property (!$past(rst) && !loopback_en |->
      modem_line_status == {!$past(cd_n), !$past(ri_n), !$past(dsr_n), !$past(cts_n)})
      else $error("status");
   c_loop: cover property (loopback_en);
   c_keep: cover property (wr_en && !enhanced_write_en);
   c_auto: cover property (auto_rts_en && !rts_n);
endmodule // ctl_monitor
bind uart_modem_control_reg ctl_monitor u_mon(
   .clk(clk),
   .rst(rst),
   .wr_en(wr_en),
   .enhanced_write_en(enhanced_write_en),
   .auto_rts_en(auto_rts_en),
   .auto_rts_level_n(auto_rts_level_n),
   .cts_n(cts_n),
   .dsr_n(dsr_n),
   .ri_n(ri_n),
   .cd_n(cd_n),
   .loopback_en(loopback_en),
   .general_purpose_output(general_purpose_output),
   .channel_a_irq_oe(channel_a_irq_oe),
   .channel_b_irq_oe(channel_b_irq_oe),
   .rts_n(rts_n),
   .dtr_n(dtr_n),
   .wr_data(wr_data),
   .modem_control(modem_control),
   .modem_line_status(modem_line_status)
);

//--- testbench/test_uart_modem_control_reg.sv
`timescale 1ns/1ns
module test_uart_modem_control_reg;
   logic clk = 1'h0, rst = 1'h1, wr_en = 1'h0, enhanced_write_en = 1'h0, auto_rts_en = 1'h0;
   logic tx_serial = 1'h1, auto_rts_level_n = 1'h0, irq_a_in = 1'h1, irq_b_in = 1'h0;
   logic rx_pin, cts_n, dsr_n, ri_n, cd_n;
   logic baud_tick, thresholds_access_en, xon_any_en, loopback_en, fifo_ready_en, rx_serial;
   logic tx_pin, channel_a_irq_out, channel_a_irq_oe, channel_b_irq_out, channel_b_irq_oe;
   logic general_purpose_output, rts_n, dtr_n;
   logic [7:0] wr_data = 8'h00, modem_control;
   logic [3:0] modem_line_status, peer_set = 4'h5;
   int n_errors = 0, n_compared = 0, n;
   always #4 clk = ~clk;
   uart_modem_control_reg u_dut(.*);
   modem_peer u_peer(.peer_set, .tx_pin, .lines_n({cd_n, ri_n, dsr_n, cts_n}), .rx_pin);
   task report_and_stop;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // outputs show a write two edges after the strobe
   task wr(input logic [7:0] d, input logic e);
      wr_en = 1'h1;
      wr_data = d;
      enhanced_write_en = e;
      @(posedge clk);
      #1 wr_en = 1'h0;
      @(posedge clk);
      #1;
   endtask
   task ticks(input logic [7:0] want);
      n = 0;
      repeat (16) begin
         @(posedge clk);
         #1 n += baud_tick;
      end
      chk(n[7:0], want);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 1'h0;
      chk({rts_n, dtr_n, general_purpose_output, modem_control[4:0]}, 8'hE0);
      wr(8'hE6, 1'h1);
      chk(modem_control, 8'hE6);
      chk({thresholds_access_en, xon_any_en, fifo_ready_en, general_purpose_output,
         channel_a_irq_oe, rts_n, dtr_n, loopback_en}, 8'hF2);
      chk({4'h0, modem_line_status}, 8'h05);
      ticks(8'h04);
      tx_serial = 1'h0;
      wr(8'h19, 1'h0);
      chk(modem_control, 8'hF9);
      chk({loopback_en, tx_pin, rx_serial, general_purpose_output,
         modem_line_status}, 8'hCA);
      chk({4'h0, dtr_n, rts_n, channel_a_irq_oe, channel_b_irq_oe}, 8'h07);
      auto_rts_en = 1'h1;
      peer_set = 4'hA;
      wr(8'h00, 1'h1);
      chk({rts_n, modem_control[6:0]}, 8'h00);
      chk({4'h0, modem_line_status}, 8'h0A);
      ticks(8'h10);
      chk({thresholds_access_en, xon_any_en, fifo_ready_en, loopback_en, tx_pin, rx_serial,
         channel_a_irq_out, channel_b_irq_out}, 8'h02);
      report_and_stop;
   end
   initial begin
      #2000;
      n_errors++;
      report_and_stop;
   end
endmodule // test_uart_modem_control_reg
